// File: inc/hspm_pkg.sv
// Package: offsets, field positions, reset values for the hot swap and
// power management extension registers.
// Assumes a configuration access port with dword address and byte enables.
package hspm_pkg;

  // Dword-aligned configuration offsets
  localparam logic [7:0] PM_DATA_OFFSET = 8'hE0;
  localparam logic [7:0] HS_OFFSET = 8'hE4;

  // Capability entry constants
  localparam logic [7:0] HOTSWAP_ID_FIELD_VALUE = 8'h06;
  localparam logic [7:0] HS_NEXT_VALUE = 8'h00;

  // Bit positions within the 32-bit dword
  localparam int BUS_PWR_CLK_BIT = 23;
  localparam int CLK_STOP_D3_BIT = 22;
  localparam int INSERT_BIT = 23;
  localparam int EXTRACT_BIT = 22;
  localparam int LED_BIT = 19;
  localparam int ENUM_MASK_BIT = 17;

  // Byte lanes
  localparam int BYTE0_LANE = 0;
  localparam int BYTE2_LANE = 2;

  // Power state encodings
  localparam logic [1:0] PWR_D0 = 2'h0;
  localparam logic [1:0] PWR_D3 = 2'h3;

  // Reset values
  localparam logic RESET_FLAG = 1'b0;
  localparam logic [1:0] RESET_PWR = 2'h0;

  // Secondary clock divider: secondary clock is primary divided by two
  localparam int PRIMARY_CLK_NS = 20;
  localparam int SEC_CLK_NS = 40;
  localparam int SEC_DIV_HALF = SEC_CLK_NS / PRIMARY_CLK_NS / 2;

  // Power states of the block
  typedef enum logic [1:0] {HSPM_D0, HSPM_D3} hspm_pwr_t;

endpackage

// File: src/hspm_edge.sv
// Rising-edge detector for synchronous level inputs.
// Assumes the input is already synchronous to i_clk.
`timescale 1ns/100ps
module hspm_edge (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Level in, pulse out
  input wire logic i_level,
  output logic o_rise
);

  logic prev_q;
  logic prev_d;

  // Next value of the delayed level
  always_comb begin
    prev_d = i_level;
  end

  // Delay register
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end

  // One-cycle pulse on a rising level
  assign o_rise = i_level & ~prev_q;

endmodule

// File: src/hspm_regs.sv
// Hot swap capability and power management bridge-support registers.
// Assumes single-cycle configuration accesses, inputs synchronous to i_clk.
`timescale 1ns/100ps
module hspm_regs (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Configuration access
  input wire logic i_cfg_rd,
  input wire logic i_cfg_wr,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [3:0] i_cfg_be_n,
  input wire logic [31:0] i_cfg_wdata,
  output logic [31:0] o_cfg_rdata,
  // Board and strap inputs
  input wire logic i_clock_control_strap,
  input wire logic i_handle_closed,
  input wire logic i_extract_req,
  // Indicator, enumeration, secondary clock and power state outputs
  output logic o_enum_n,
  output logic o_led,
  output logic o_sec_clk,
  output logic [1:0] o_power_state_field
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic insertion_flag_q, insertion_flag_d;
  logic extract_flag_q, extract_flag_d;
  logic led_on_ctl_q, led_on_ctl_d;
  logic enum_mask_q, enum_mask_d;
  hspm_pkg::hspm_pwr_t pwr_q, pwr_d;
  logic armed_q, armed_d;
  logic sec_clk_q, sec_clk_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] bse_byte;
  logic [7:0] csr_byte;
  logic hs_wr, pm_wr, extract_rise;
  logic secondary_clock_stop_in_d3;
  logic bus_power_clock_ctl_en;

  ////////////////////////////////////////////////////////////////////////
  // Decode

  // Writes reach a register only with its byte lane enabled (active low)
  assign hs_wr = i_cfg_wr && (i_cfg_addr == hspm_pkg::HS_OFFSET)
                 && !i_cfg_be_n[hspm_pkg::BYTE2_LANE];
  assign pm_wr = i_cfg_wr && (i_cfg_addr == hspm_pkg::PM_DATA_OFFSET)
                 && !i_cfg_be_n[hspm_pkg::BYTE0_LANE];

  // Strap mirror bits
  assign bus_power_clock_ctl_en = i_clock_control_strap;
  assign secondary_clock_stop_in_d3 = i_clock_control_strap;

  // Edge of the board removal request
  hspm_edge u_extract_edge (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_level(i_extract_req),
    .o_rise(extract_rise)
  );

  ////////////////////////////////////////////////////////////////////////
  // Hot swap control and status

  // Flags: hardware set beats software write-one-clear
  always_comb begin
    insertion_flag_d = insertion_flag_q;
    extract_flag_d = extract_flag_q;
    led_on_ctl_d = led_on_ctl_q;
    enum_mask_d = enum_mask_q;
    armed_d = armed_q;
    if (hs_wr && i_cfg_wdata[hspm_pkg::INSERT_BIT]) begin
      insertion_flag_d = 1'b0;
    end
    if (hs_wr && i_cfg_wdata[hspm_pkg::EXTRACT_BIT]) begin
      extract_flag_d = 1'b0;
    end
    if (hs_wr) begin
      led_on_ctl_d = i_cfg_wdata[hspm_pkg::LED_BIT];
      enum_mask_d = i_cfg_wdata[hspm_pkg::ENUM_MASK_BIT];
    end
    // Reset released and handle closed: raise insertion once
    if (!armed_q && i_handle_closed) begin
      insertion_flag_d = 1'b1;
      armed_d = 1'b1;
    end
    if (!i_handle_closed) begin
      armed_d = 1'b0;
    end
    if (extract_rise) begin
      extract_flag_d = 1'b1;
    end
  end

  // Status registers
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      insertion_flag_q <= hspm_pkg::RESET_FLAG;
      extract_flag_q <= hspm_pkg::RESET_FLAG;
      led_on_ctl_q <= hspm_pkg::RESET_FLAG;
      enum_mask_q <= hspm_pkg::RESET_FLAG;
      armed_q <= 1'b0;
    end else begin
      insertion_flag_q <= insertion_flag_d;
      extract_flag_q <= extract_flag_d;
      led_on_ctl_q <= led_on_ctl_d;
      enum_mask_q <= enum_mask_d;
      armed_q <= armed_d;
    end
  end

  // Enumeration and LED outputs
  assign o_enum_n = ~((insertion_flag_q | extract_flag_q)
                      & ~enum_mask_q);
  assign o_led = led_on_ctl_q;

  ////////////////////////////////////////////////////////////////////////
  // Power state

  // Unimplemented states leave the field unchanged
  always_comb begin
    pwr_d = pwr_q;
    if (pm_wr) begin
      unique case (i_cfg_wdata[1:0])
        hspm_pkg::PWR_D0: pwr_d = hspm_pkg::HSPM_D0;
        hspm_pkg::PWR_D3: pwr_d = hspm_pkg::HSPM_D3;
        default: pwr_d = pwr_q;
      endcase
    end
  end

  // Power state register
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      pwr_q <= hspm_pkg::HSPM_D0;
    end else begin
      pwr_q <= pwr_d;
    end
  end

  assign o_power_state_field = (pwr_q == hspm_pkg::HSPM_D3) ?
                               hspm_pkg::PWR_D3 : hspm_pkg::PWR_D0;

  ////////////////////////////////////////////////////////////////////////
  // Secondary clock

  // Primary clock divided by two; held low in D3 when strap stops it
  always_comb begin
    sec_clk_d = ~sec_clk_q;
    if (secondary_clock_stop_in_d3 && pwr_q == hspm_pkg::HSPM_D3) begin
      sec_clk_d = 1'b0;
    end
  end

  // Divider register
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      sec_clk_q <= 1'b0;
    end else begin
      sec_clk_q <= sec_clk_d;
    end
  end

  assign o_sec_clk = sec_clk_q;

  ////////////////////////////////////////////////////////////////////////
  // Read path

  // Byte images of the composite registers
  assign bse_byte = {bus_power_clock_ctl_en, secondary_clock_stop_in_d3,
                     6'h00};
  assign csr_byte = {insertion_flag_q, extract_flag_q, 2'h0, led_on_ctl_q,
                     1'b0, enum_mask_q, 1'b0};

  // Registered read data, unmapped offsets read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (i_cfg_rd) begin
      unique case (i_cfg_addr)
        hspm_pkg::PM_DATA_OFFSET: begin
          rdata_d = {8'h00, bse_byte, 14'h0000, o_power_state_field};
        end
        hspm_pkg::HS_OFFSET: begin
          rdata_d = {8'h00, csr_byte, hspm_pkg::HS_NEXT_VALUE,
                     hspm_pkg::HOTSWAP_ID_FIELD_VALUE};
        end
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_cfg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_strap_mirror;
    @(posedge i_clk) disable iff (!i_resetn)
      i_cfg_rd && i_cfg_addr == hspm_pkg::PM_DATA_OFFSET |=>
        o_cfg_rdata[23:22] == {2{$past(i_clock_control_strap)}};
  endproperty
  a_strap_mirror: assert property (p_strap_mirror)
    else $error("strap mirror bits wrong");

  property p_clock_stopped;
    @(posedge i_clk) disable iff (!i_resetn)
      i_clock_control_strap && pwr_q == hspm_pkg::HSPM_D3 |=> !o_sec_clk;
  endproperty
  a_clock_stopped: assert property (p_clock_stopped)
    else $error("secondary clock runs in D3");

  property p_clock_runs;
    @(posedge i_clk) disable iff (!i_resetn)
      !i_clock_control_strap && $past(i_resetn) |=>
        o_sec_clk != $past(o_sec_clk);
  endproperty
  a_clock_runs: assert property (p_clock_runs)
    else $error("secondary clock not toggling");

  property p_reserved_zero;
    @(posedge i_clk) disable iff (!i_resetn)
      i_cfg_rd && i_cfg_addr == hspm_pkg::PM_DATA_OFFSET |=>
        o_cfg_rdata[21:16] == 6'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved support bits set");

  property p_cap_words;
    @(posedge i_clk) disable iff (!i_resetn)
      i_cfg_rd && i_cfg_addr == hspm_pkg::HS_OFFSET |=>
        o_cfg_rdata[15:0] == 16'h0006 && o_cfg_rdata[21:20] == 2'h0
        && o_cfg_rdata[18] == 1'b0 && o_cfg_rdata[16] == 1'b0;
  endproperty
  a_cap_words: assert property (p_cap_words)
    else $error("capability header or status zeros wrong");

  property p_insert_cause;
    @(posedge i_clk) disable iff (!i_resetn)
      $rose(insertion_flag_q) |-> $past(i_handle_closed);
  endproperty
  a_insert_cause: assert property (p_insert_cause)
    else $error("insertion set without closed handle");

  property p_enum_out;
    @(posedge i_clk) disable iff (!i_resetn)
      o_enum_n == !((insertion_flag_q || extract_flag_q) && !enum_mask_q);
  endproperty
  a_enum_out: assert property (p_enum_out)
    else $error("enumeration output mismatch");

  property p_extract_set;
    @(posedge i_clk) disable iff (!i_resetn)
      $rose(i_extract_req) |=> extract_flag_q;
  endproperty
  a_extract_set: assert property (p_extract_set)
    else $error("extraction flag not set");

  property p_led_write;
    @(posedge i_clk) disable iff (!i_resetn)
      hs_wr |=> o_led == $past(i_cfg_wdata[19]);
  endproperty
  a_led_write: assert property (p_led_write)
    else $error("LED did not follow write");

  property p_pwr_code;
    @(posedge i_clk) disable iff (!i_resetn)
      o_power_state_field == 2'h0 || o_power_state_field == 2'h3;
  endproperty
  a_pwr_code: assert property (p_pwr_code)
    else $error("illegal power state code");

  c_insert: cover property (@(posedge i_clk) $rose(insertion_flag_q));
  c_extract_clear: cover property (@(posedge i_clk)
    extract_flag_q ##1 !extract_flag_q);
  c_masked: cover property (@(posedge i_clk) enum_mask_q && extract_flag_q);
  c_d3_stop: cover property (@(posedge i_clk)
    i_clock_control_strap && pwr_q == hspm_pkg::HSPM_D3);

endmodule

// File: verification/hspm_host.sv
// Host model: issues configuration reads and writes to the register block.
// Assumes requests are taken at the rising edge, read data one cycle later.
`timescale 1ns/100ps
module hspm_host (
  // Clock
  input wire logic i_clk,
  // Configuration access towards the block
  output logic o_cfg_rd,
  output logic o_cfg_wr,
  output logic [7:0] o_cfg_addr,
  output logic [3:0] o_cfg_be_n,
  output logic [31:0] o_cfg_wdata,
  input wire logic [31:0] i_cfg_rdata
);
  ////////////////////////////////////////////////////////////////////////////
  // Idle bus at time zero
  initial begin
    o_cfg_rd = 1'b0;
    o_cfg_wr = 1'b0;
    o_cfg_addr = 8'h00;
    o_cfg_be_n = 4'hF;
    o_cfg_wdata = 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One access, driven at the falling edge, held over one rising edge
  task automatic cfg(input logic wr, input logic [7:0] a,
                     input logic [3:0] ben, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(negedge i_clk);
    o_cfg_rd = ~wr;
    o_cfg_wr = wr;
    o_cfg_addr = a;
    o_cfg_be_n = ben;
    o_cfg_wdata = wd;
    @(negedge i_clk);
    rd = i_cfg_rdata;
    o_cfg_rd = 1'b0;
    o_cfg_wr = 1'b0;
    // Stale address and data are inverted so they never look valid
    o_cfg_addr = ~a;
    o_cfg_be_n = 4'hF;
    o_cfg_wdata = ~wd;
  endtask
endmodule

// File: verification/tb.sv
// Testbench: reference model of the hot swap and bridge-support registers.
// Assumes the host model drives the access port and the bench the pins.
`timescale 1ns/100ps
module tb;
  // Clock, reset, pins and bus wires
  logic i_clk;
  logic i_resetn;
  logic strap, handle, extract, rd, wr, enum_n, led, sec_clk, last;
  logic [7:0] addr;
  logic [3:0] be_n;
  logic [31:0] wdata, rdata, got, r;
  logic [1:0] pwr;
  // Reference model state and counters
  logic insert_m, ext, led_m, mask;
  logic [1:0] pwr_m;
  integer bad_count = 0;
  integer total_checks = 0;
  integer seed = 32'h3d97;
  integer n;

  hspm_regs DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_cfg_rd(rd),
    .i_cfg_wr(wr), .i_cfg_addr(addr), .i_cfg_be_n(be_n),
    .i_cfg_wdata(wdata), .o_cfg_rdata(rdata),
    .i_clock_control_strap(strap), .i_handle_closed(handle),
    .i_extract_req(extract), .o_enum_n(enum_n), .o_led(led),
    .o_sec_clk(sec_clk), .o_power_state_field(pwr));
  hspm_host host (.i_clk(i_clk), .o_cfg_rd(rd), .o_cfg_wr(wr),
    .o_cfg_addr(addr), .o_cfg_be_n(be_n), .o_cfg_wdata(wdata),
    .i_cfg_rdata(rdata));

  ////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  // Hot swap dword and the pins that follow it
  task automatic chk_hs();
    logic [7:0] c;
    logic en;
    c = {insert_m, ext, 2'b00, led_m, 1'b0, mask, 1'b0};
    en = ~((insert_m | ext) & ~mask);
    host.cfg(1'b0, 8'hE4, 4'h0, 32'h0, got);
    chk("hs dword", {8'h00, c, 8'h00, 8'h06}, got);
    chk("enum_n", {31'h0, en}, {31'h0, enum_n});
    chk("led", {31'h0, led_m}, {31'h0, led});
  endtask

  // Status write; lane 2 disabled when en is low
  task automatic wr_hs(input logic [7:0] c, input logic en);
    r = $random(seed);
    host.cfg(1'b1, 8'hE4, {r[3], ~en, r[1:0]}, {r[31:24], c, r[15:0]}, got);
    if (en) begin
      if (c[7]) insert_m = 1'b0;
      if (c[6]) ext = 1'b0;
      led_m = c[3];
      mask = c[1];
    end
  endtask

  // Power field write, then read back
  task automatic pm(input logic [1:0] p);
    r = $random(seed);
    host.cfg(1'b1, 8'hE0, {r[3:1], 1'b0}, {r[31:2], p}, got);
    if (p == 2'h0 || p == 2'h3) pwr_m = p;
    host.cfg(1'b0, 8'hE0, 4'h0, 32'h0, got);
    chk("pm dword", {8'h00, strap, strap, 20'h0, pwr_m}, got);
    chk("pwr pins", {30'h0, pwr_m}, {30'h0, pwr});
  endtask

  // Count secondary clock changes over eight cycles
  task automatic sec_count(input integer e);
    repeat (2) @(negedge i_clk);
    n = 0;
    last = sec_clk;
    repeat (8) begin
      @(negedge i_clk);
      if (sec_clk !== last) n++;
      last = sec_clk;
    end
    chk("sec clk changes", e, n);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    i_resetn = 1'b0;
    r = $random(seed);
    strap = r[0];
    handle = 1'b0;
    extract = 1'b0;
    {insert_m, ext, led_m, mask, pwr_m} = 6'h00;
    repeat (6) @(negedge i_clk);
    i_resetn = 1'b1;
    chk_hs();
    pm(2'h1);
    host.cfg(1'b0, 8'hE8, 4'h0, 32'h0, got);
    chk("unmapped", 32'h0, got);
    $display("test reset done");
    // Insertion on handle closure, masked, then cleared
    handle = 1'b1;
    insert_m = 1'b1;
    chk_hs();
    wr_hs(8'h02, 1'b1);
    chk_hs();
    wr_hs(8'h80, 1'b1);
    chk_hs();
    $display("test insertion done");
    // Extraction, ignored write, then clear with LED on and off
    extract = 1'b1;
    ext = 1'b1;
    chk_hs();
    wr_hs(8'h48, 1'b0);
    chk_hs();
    wr_hs(8'h48, 1'b1);
    chk_hs();
    wr_hs(8'h00, 1'b1);
    chk_hs();
    $display("test extraction done");
    // Secondary clock against strap and power state
    strap = 1'b0;
    sec_count(8);
    pm(2'h3);
    sec_count(8);
    strap = 1'b1;
    sec_count(0);
    chk("sec clk level", 32'h0, {31'h0, sec_clk});
    pm(2'h2);
    $display("test power done");
    // Mid-run reset with handle still closed: insertion raised again
    i_resetn = 1'b0;
    extract = 1'b0;
    repeat (6) @(negedge i_clk);
    i_resetn = 1'b1;
    {insert_m, ext, led_m, mask, pwr_m} = 6'h00;
    insert_m = 1'b1;
    chk_hs();
    pm(2'h1);
    $display("test reset again done");
    finish_test();
  end
endmodule
